// [hdl/bxo_pin_drv.sv]
/*
  Pin driver: turns the enable, power-down and disabled-state controls
  into registered levels and an output enable for the pin pair.
  Assumes the clock to be passed is a synchronous level input.
*/
`timescale 1ns/100ps
`default_nettype none
module bxo_pin_drv
  import bxo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  bxo_pin_if.drv pins
);

  logic true_q;
  logic comp_q;
  logic oe_q;

  // ****************************************
  // Pin state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      true_q <= 1'b0;
      comp_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (pins.power_off)
    begin
      // Power-down overrides every enable source
      true_q <= 1'b0;
      comp_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (pins.disabled && pins.dis_state != BXO_DIS_RUN)
    begin
      case (pins.dis_state)
        BXO_DIS_LOW:
        begin
          true_q <= 1'b0;
          comp_q <= (pins.drv_mode == BXO_MODE_LVDS);
          oe_q <= 1'b1;
        end
        BXO_DIS_LOWHIGH:
        begin
          true_q <= 1'b0;
          comp_q <= 1'b1;
          oe_q <= 1'b1;
        end
        default:
        begin
          true_q <= 1'b0;
          comp_q <= 1'b0;
          oe_q <= 1'b0;
        end
      endcase
    end
    else
    begin
      // CMOS drives both legs in opposite phase, as do the differential types
      true_q <= pins.clk_in;
      comp_q <= ~pins.clk_in;
      oe_q <= 1'b1;
    end
  end

  assign pins.pin_true = true_q;
  assign pins.pin_comp = comp_q;
  assign pins.pin_oe = oe_q;

endmodule
`default_nettype wire

// [hdl/bxo_pin_if.sv]
/*
  Interface carrying the driver pin pair and its enables between
  the register bank and the pin driver module.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface bxo_pin_if;
  logic [1:0] drv_mode;
  logic [1:0] dis_state;
  logic disabled;
  logic power_off;
  logic clk_in;
  logic pin_true;
  logic pin_comp;
  logic pin_oe;

  modport ctrl
  (
    output drv_mode,
    output dis_state,
    output disabled,
    output power_off,
    output clk_in,
    input pin_true,
    input pin_comp,
    input pin_oe
  );

  modport drv
  (
    input drv_mode,
    input dis_state,
    input disabled,
    input power_off,
    input clk_in,
    output pin_true,
    output pin_comp,
    output pin_oe
  );
endinterface
`default_nettype wire

// [hdl/bxo_pkg.sv]
/*
  Package of the bias, crystal and output control register bank:
  APB offsets, field positions, reset values and driver encodings.
  Assumes a 32-bit APB with one aligned word per register.
*/
package bxo_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] BXO_OFS_BIAS_CALIBRATION_STATUS = 8'h00;
  localparam logic [7:0] BXO_OFS_XO_CFG = 8'h04;
  localparam logic [7:0] BXO_OFS_OD_CFG = 8'h08;
  localparam logic [7:0] BXO_OFS_DRV_EN = 8'h0C;
  localparam logic [7:0] BXO_OFS_DRV_MODE = 8'h10;
  localparam logic [7:0] BXO_OFS_IRQ_STS = 8'h14;
  localparam logic [7:0] BXO_OFS_IRQ_MASK = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BXO_BIT_CAL_DONE = 0;
  localparam int BXO_BIT_CAL_FAIL = 1;
  localparam int BXO_POS_CAL_SEL = 2;
  localparam int BXO_POS_CAL_EFF = 5;
  localparam int BXO_BIT_CMP_RAW = 8;
  localparam int BXO_POS_GAIN = 14;
  localparam int BXO_BIT_XO_REG = 16;
  localparam int BXO_POS_XO_SPARE = 17;
  localparam int BXO_BIT_OD_REG = 15;
  localparam int BXO_POS_DIS_STATE = 2;
  localparam int BXO_BIT_DIS = 1;
  localparam int BXO_BIT_PD = 0;
  localparam int BXO_BIT_IRQ_DONE = 0;
  localparam int BXO_BIT_IRQ_FAIL = 1;

  // ****************************************
  // Reset values, write masks and minimum divide ratio
  // ****************************************
  localparam logic [31:0] BXO_RST_XO_CFG = 32'h0001_5F1F;
  localparam logic [31:0] BXO_XO_WMASK = 32'h0007_FFFF;
  localparam logic [15:0] BXO_RST_OD_CFG = 16'h8069;
  localparam logic [15:0] BXO_OD_WMASK = 16'hBFFF;
  localparam logic [7:0] BXO_RST_DRV_EN = 8'h00;
  localparam logic [7:0] BXO_DRV_EN_WMASK = 8'h0F;
  localparam logic [1:0] BXO_RST_DRV_MODE = 2'h0;
  localparam logic [13:0] BXO_MIN_RATIO = 14'h000A;

  // ****************************************
  // Driver type and disabled state codes
  // ****************************************
  localparam logic [1:0] BXO_MODE_HCSL = 2'h0;
  localparam logic [1:0] BXO_MODE_LVDS = 2'h2;
  localparam logic [1:0] BXO_MODE_CMOS = 2'h3;
  localparam logic [1:0] BXO_DIS_LOW = 2'h0;
  localparam logic [1:0] BXO_DIS_LOWHIGH = 2'h1;
  localparam logic [1:0] BXO_DIS_HIZ = 2'h2;
  localparam logic [1:0] BXO_DIS_RUN = 2'h3;

endpackage

// [hdl/bxo_regs.sv]
/*
  Register bank for bias calibration status, crystal oscillator,
  output divider and output driver control, reached over APB.
  Assumes calibration status inputs are synchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module bxo_regs
  import bxo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_done,
  input wire logic cal_fail,
  input wire logic [2:0] cal_sel,
  input wire logic [2:0] cal_eff,
  input wire logic cal_cmp_raw,
  input wire logic output_enable,
  input wire logic clk_src,
  output logic crystal_regulator_on,
  output logic [1:0] gain_boost_count,
  output logic divider_regulator_on,
  output logic [13:0] divide_ratio,
  output logic driver_power_off,
  output logic clock_pin_true,
  output logic clock_pin_true_oe,
  output logic clock_pin_complement,
  output logic clock_pin_complement_oe,
  output logic irq
);

  bxo_pin_if pins ();

  logic [15:0] cal_sts_q;
  logic [31:0] xo_cfg_q;
  logic [15:0] od_cfg_q;
  logic [7:0] drv_en_q;
  logic [1:0] drv_mode_q;
  logic [1:0] irq_sts_q;
  logic [1:0] irq_mask_q;
  logic cal_done_prev_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_d;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && penable && !pwrite;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      BXO_OFS_BIAS_CALIBRATION_STATUS: rd_d = {16'h0000, cal_sts_q};
      BXO_OFS_XO_CFG: rd_d = xo_cfg_q;
      BXO_OFS_OD_CFG: rd_d = {16'h0000, od_cfg_q};
      BXO_OFS_DRV_EN: rd_d = {24'h000000, drv_en_q};
      BXO_OFS_DRV_MODE: rd_d = {30'h00000000, drv_mode_q};
      BXO_OFS_IRQ_STS: rd_d = {30'h00000000, irq_sts_q};
      BXO_OFS_IRQ_MASK: rd_d = {30'h00000000, irq_mask_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data is registered, so prdata comes out of a flip-flop; the
  // combinational read value is captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_q <= 1'b0;
    else if (psel && !penable)
      pslverr_q <= !addr_ok;
  end

  assign prdata = rd_en ? prdata_q : 32'h0000_0000;
  assign pslverr = psel && penable && pslverr_q;

  // ****************************************
  // Calibration status, read only
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_sts_q <= 16'h0000;
    else
    begin
      // Software writes never reach this register
      cal_sts_q <= 16'h0000;
      cal_sts_q[BXO_BIT_CAL_DONE] <= cal_done;
      cal_sts_q[BXO_BIT_CAL_FAIL] <= cal_fail;
      cal_sts_q[BXO_POS_CAL_SEL +: 3] <= cal_sel;
      cal_sts_q[BXO_POS_CAL_EFF +: 3] <= cal_eff;
      cal_sts_q[BXO_BIT_CMP_RAW] <= cal_cmp_raw;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xo_cfg_q <= BXO_RST_XO_CFG;
    else if (wr_en && paddr == BXO_OFS_XO_CFG)
      xo_cfg_q <= pwdata & BXO_XO_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      od_cfg_q <= BXO_RST_OD_CFG;
    else if (wr_en && paddr == BXO_OFS_OD_CFG)
      od_cfg_q <= pwdata[15:0] & BXO_OD_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drv_en_q <= BXO_RST_DRV_EN;
    else if (wr_en && paddr == BXO_OFS_DRV_EN)
      drv_en_q <= pwdata[7:0] & BXO_DRV_EN_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drv_mode_q <= BXO_RST_DRV_MODE;
    else if (wr_en && paddr == BXO_OFS_DRV_MODE)
      drv_mode_q <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_q <= 2'h0;
    else if (wr_en && paddr == BXO_OFS_IRQ_MASK)
      irq_mask_q <= pwdata[1:0];
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cal_done_prev_q <= 1'b0;
    else
      cal_done_prev_q <= cal_done;
  end

  assign irq_set[BXO_BIT_IRQ_DONE] = cal_done && !cal_done_prev_q;
  assign irq_set[BXO_BIT_IRQ_FAIL] = cal_done && !cal_done_prev_q && cal_fail;
  assign irq_clr = (wr_en && paddr == BXO_OFS_IRQ_STS) ? pwdata[1:0] : 2'h0;

  // A new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_q <= 2'h0;
    else
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
  end

  assign irq = |(irq_sts_q & irq_mask_q);

  // ****************************************
  // Analog controls
  // ****************************************
  assign crystal_regulator_on = xo_cfg_q[BXO_BIT_XO_REG];
  assign gain_boost_count = xo_cfg_q[BXO_POS_GAIN +: 2];
  assign divider_regulator_on = od_cfg_q[BXO_BIT_OD_REG];
  // Values below the minimum are passed as written; software keeps them legal
  assign divide_ratio = od_cfg_q[13:0];
  assign driver_power_off = drv_en_q[BXO_BIT_PD];

  // ****************************************
  // Output driver
  // ****************************************
  assign pins.drv_mode = drv_mode_q;
  assign pins.dis_state = drv_en_q[BXO_POS_DIS_STATE +: 2];
  // Disabled by the register bit or by the external enable input
  assign pins.disabled = drv_en_q[BXO_BIT_DIS] || !output_enable;
  assign pins.power_off = drv_en_q[BXO_BIT_PD];
  assign pins.clk_in = clk_src;

  bxo_pin_drv u_pin_drv
  (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins)
  );

  assign clock_pin_true = pins.pin_true;
  assign clock_pin_complement = pins.pin_comp;
  assign clock_pin_true_oe = pins.pin_oe;
  assign clock_pin_complement_oe = pins.pin_oe;

endmodule
`default_nettype wire

// [tb/bxo_regs_chk.sv]
/*
  Checker of the register bank ports: APB answer, control outputs, pins, irq.
  Assumes it is bound into bxo_regs and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module bxo_regs_chk
  import bxo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic crystal_regulator_on,
  input wire logic [1:0] gain_boost_count,
  input wire logic divider_regulator_on,
  input wire logic [13:0] divide_ratio,
  input wire logic driver_power_off,
  input wire logic clock_pin_true,
  input wire logic clock_pin_true_oe,
  input wire logic clock_pin_complement,
  input wire logic clock_pin_complement_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // **********
  // Properties
  // **********
  sequence acc_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence acc_any;
    psel && penable;
  endsequence
  sequence acc_wr_low(logic [7:0] a, logic [1:0] v);
    psel && penable && pwrite && paddr == a && pwdata[1:0] == v;
  endsequence
  ready_always_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (acc_any |-> pslverr == (paddr[1:0] != 2'h0 || paddr > BXO_OFS_IRQ_MASK))
    else $error("pslverr wrong");
  reset_values_a: assert property ($rose(presetn) |-> crystal_regulator_on && gain_boost_count == 2'h1
    && divider_regulator_on && divide_ratio == 14'h0069 && !driver_power_off) else $error("bad reset value");
  xo_write_a: assert property (acc_wr(BXO_OFS_XO_CFG) |=> crystal_regulator_on == $past(pwdata[16])
    && gain_boost_count == $past(pwdata[15:14])) else $error("xo write lost");
  od_write_a: assert property (acc_wr(BXO_OFS_OD_CFG) |=> divider_regulator_on == $past(pwdata[15])
    && divide_ratio == $past(pwdata[13:0])) else $error("od write lost");
  pd_write_a: assert property (acc_wr(BXO_OFS_DRV_EN) |=> driver_power_off == $past(pwdata[0]))
    else $error("power off write lost");
  pd_tristate_a: assert property (driver_power_off |=> !clock_pin_true_oe && !clock_pin_complement_oe)
    else $error("pins driven in power off");
  hiz_quiet_a: assert property (!clock_pin_true_oe |-> !clock_pin_true && !clock_pin_complement)
    else $error("hi-z pin level");
  pair_oe_a: assert property (clock_pin_true_oe == clock_pin_complement_oe) else $error("oe split");
  irq_masked_a: assert property (acc_wr_low(BXO_OFS_IRQ_MASK, 2'h0) |-> ##2 !irq)
    else $error("irq while masked");
endmodule
bind bxo_regs bxo_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .crystal_regulator_on(crystal_regulator_on), .gain_boost_count(gain_boost_count),
  .divider_regulator_on(divider_regulator_on), .divide_ratio(divide_ratio),
  .driver_power_off(driver_power_off), .clock_pin_true(clock_pin_true), .clock_pin_true_oe(clock_pin_true_oe),
  .clock_pin_complement(clock_pin_complement), .clock_pin_complement_oe(clock_pin_complement_oe), .irq(irq));
`default_nettype wire

// [tb/test_bias_xo_output_ctrl_regs.sv]
/*
  Self-checking bench of the register bank: random and corner APB traffic,
  calibration inputs, driver pin states and the interrupt.
  Assumes the bank is the only APB slave and clk_src is a level.
*/
`timescale 1ns/100ps
`default_nettype none
module test_bias_xo_output_ctrl_regs
  import bxo_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h5E79E1CF;
  logic cal_done = 1'b0, cal_fail = 1'b0, cal_cmp_raw = 1'b0, output_enable = 1'b1, clk_src = 1'b1;
  logic [2:0] cal_sel = 3'h0, cal_eff = 3'h0;
  logic pready, pslverr, xo_on, od_on, pd, pt, pto, pc, pco, irq;
  logic [1:0] gain;
  logic [13:0] ratio;
  int failures = 0, tests_run = 0;
  always #25 pclk = ~pclk;
  bxo_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cal_done(cal_done),
    .cal_fail(cal_fail), .cal_sel(cal_sel), .cal_eff(cal_eff), .cal_cmp_raw(cal_cmp_raw),
    .output_enable(output_enable), .clk_src(clk_src), .crystal_regulator_on(xo_on), .gain_boost_count(gain),
    .divider_regulator_on(od_on), .divide_ratio(ratio), .driver_power_off(pd), .clock_pin_true(pt),
    .clock_pin_true_oe(pto), .clock_pin_complement(pc), .clock_pin_complement_oe(pco), .irq(irq));
  // **********
  // Helpers
  // **********
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Held pins as {oe, oe, true, complement}; hi-Z shows level 0
  function automatic logic [3:0] pin_exp(logic [1:0] m, logic [1:0] s);
    if (s == BXO_DIS_HIZ)
      return 4'h0;
    return {3'h6, s == BXO_DIS_LOWHIGH || m == BXO_MODE_LVDS};
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      close_out();
    end
  endtask
  task automatic rdc(string n, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic pins(logic [3:0] e);
    repeat (2) @(posedge pclk);
    chk("pins", e, {pco, pto, pt, pc});
  endtask
  task automatic irqc(logic e);
    repeat (2) @(posedge pclk);
    chk("irq", e, irq);
  endtask
  // **********
  // Stimulus
  // **********
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc("xo", BXO_OFS_XO_CFG, BXO_RST_XO_CFG);
    rdc("od", BXO_OFS_OD_CFG, {16'h0, BXO_RST_OD_CFG});
    rdc("drv", BXO_OFS_DRV_EN, 32'h0);
    rdc("sts", BXO_OFS_BIAS_CALIBRATION_STATUS, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      // Software never programs a divide ratio below the minimum
      if (rnd[13:0] < BXO_MIN_RATIO)
        rnd[13:0] = BXO_MIN_RATIO;
      {cal_cmp_raw, cal_eff, cal_sel, cal_fail, cal_done} <= rnd[8:0];
      apb(1'b1, BXO_OFS_BIAS_CALIBRATION_STATUS, ~rnd);
      rdc("sts", BXO_OFS_BIAS_CALIBRATION_STATUS, {23'h0, rnd[8:0]});
      apb(1'b1, BXO_OFS_XO_CFG, rnd);
      rdc("xo", BXO_OFS_XO_CFG, rnd & BXO_XO_WMASK);
      chk("xo_out", {rnd[16], rnd[15:14]}, {xo_on, gain});
      apb(1'b1, BXO_OFS_OD_CFG, rnd);
      rdc("od", BXO_OFS_OD_CFG, rnd & {16'h0, BXO_OD_WMASK});
      chk("od_out", {rnd[15], rnd[13:0]}, {od_on, ratio});
      apb(1'b1, BXO_OFS_DRV_EN, rnd & 32'hFFFF_FFF7);
      rdc("drv", BXO_OFS_DRV_EN, rnd & 32'hFFFF_FFF7 & {24'h0, BXO_DRV_EN_WMASK});
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, err);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, BXO_OFS_DRV_MODE, 32'h0);
    apb(1'b1, BXO_OFS_DRV_EN, 32'h0);
    pins(4'hE);
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 3; s++)
        if (m != 1)
        begin
          apb(1'b1, BXO_OFS_DRV_MODE, m);
          apb(1'b1, BXO_OFS_DRV_EN, {s[1:0], 2'h2});
          pins(pin_exp(m[1:0], s[1:0]));
        end
    // Debug-only setting: the clock keeps running while disabled
    clk_src <= 1'b0;
    apb(1'b1, BXO_OFS_DRV_EN, 32'hE);
    pins(4'hD);
    clk_src <= 1'b1;
    output_enable <= 1'b0;
    apb(1'b1, BXO_OFS_DRV_EN, 32'h5);
    pins(4'h0);
    apb(1'b1, BXO_OFS_DRV_EN, 32'h4);
    pins(4'hD);
    cal_done <= 1'b0;
    cal_fail <= 1'b1;
    apb(1'b1, BXO_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, BXO_OFS_IRQ_STS, 32'h3);
    cal_done <= 1'b1;
    rdc("irq_sts", BXO_OFS_IRQ_STS, 32'h3);
    irqc(1'b0);
    apb(1'b1, BXO_OFS_IRQ_MASK, 32'h1);
    irqc(1'b1);
    apb(1'b1, BXO_OFS_IRQ_STS, 32'h1);
    rdc("irq_sts", BXO_OFS_IRQ_STS, 32'h2);
    irqc(1'b0);
    apb(1'b1, BXO_OFS_IRQ_MASK, 32'h3);
    irqc(1'b1);
    apb(1'b1, BXO_OFS_IRQ_STS, 32'h2);
    irqc(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
